// >>> rtl/foru_pkg.sv
// shared widths, per-format constants and enumerations of the float operand and round unit
package foru_pkg;
	// operand and datapath widths
	localparam int OPND_W = 128;
	localparam int MANT_W = 113;
	localparam int FRAC_W = 112;
	localparam int WORK_W = 116;
	localparam int HID_POS = 114;
	localparam int EXP_W = 18;
	localparam int INT_W = 32;
	localparam int CNT_W = 7;
	localparam int EXPF_W = 15;
	// last step index of the serial multiply (113 steps) and divide (116 steps)
	localparam logic [6:0] MUL_LAST = 7'h70;
	localparam logic [6:0] DIV_LAST = 7'h73;
	// exponent limits for extracting the integer part of a working value
	localparam logic signed [17:0] INT_TOP = 18'sh00073;
	localparam logic signed [17:0] RND_TOP = 18'sh00072;
	localparam logic signed [17:0] INT_MAX_K = 18'sh0001F;
	// operand formats: short, the two double-length ones and extended
	typedef enum logic [1:0] {fmt_short, fmt_double_d, fmt_double_g, fmt_extended} foru_fmt_t;
	// operations
	typedef enum logic [3:0] {
		add_op, sub_op, mul_op, div_op, cmp_op, convert_op, convert_rounded_op,
		extended_modulus_op, polynomial_eval_op, move_op, move_negated_op, clear_op, test_op
	} foru_op_t;
	// per format: stored fraction bits, exponent bias, largest biased exponent, encoding width
	localparam logic [7:0] FRAC_BITS [4] = '{8'h17, 8'h37, 8'h34, 8'h70};
	localparam logic signed [17:0] EXP_BIAS [4] = '{18'sh00080, 18'sh00080, 18'sh00400, 18'sh04000};
	localparam logic signed [17:0] EXP_MAX [4] = '{18'sh000FF, 18'sh000FF, 18'sh007FF, 18'sh07FFF};
	localparam logic [7:0] OPND_BITS [4] = '{8'h20, 8'h40, 8'h40, 8'h80};
endpackage

// >>> rtl/foru_classify.sv
// operand field split and zero / reserved classification
module foru_classify (
	// raw operand and its format
	input wire logic [foru_pkg::OPND_W-1:0] raw,
	input wire foru_pkg::foru_fmt_t fmt,
	// decoded fields
	output logic sgn,
	output logic [foru_pkg::EXPF_W-1:0] exp_field,
	output logic [foru_pkg::MANT_W-1:0] mant,
	output logic is_zero,
	output logic is_rsvd
);
	logic [foru_pkg::FRAC_W-1:0] frac;

	// fraction left aligned so all formats share one datapath
	always_comb begin
		case (fmt)
		foru_pkg::fmt_short: begin
			sgn = raw[31];
			exp_field = {7'h00, raw[30:23]};
			frac = {raw[22:0], 89'h0};
		end
		foru_pkg::fmt_double_d: begin
			sgn = raw[63];
			exp_field = {7'h00, raw[62:55]};
			frac = {raw[54:0], 57'h0};
		end
		foru_pkg::fmt_double_g: begin
			sgn = raw[63];
			exp_field = {4'h0, raw[62:52]};
			frac = {raw[51:0], 60'h0};
		end
		default: begin
			sgn = raw[127];
			exp_field = raw[126:112];
			frac = raw[111:0];
		end
		endcase
		// fraction bits are ignored once the exponent field is zero
		is_zero = !sgn && (exp_field == 15'h0);
		is_rsvd = sgn && (exp_field == 15'h0);
		// hidden bit restored for arithmetic
		mant = (is_zero || is_rsvd) ? '0 : {1'b1, frac};
	end
endmodule

// >>> rtl/foru_round.sv
// rounding, single renormalization and packing into the destination format
module foru_round (
	// normalized working value
	input wire logic [foru_pkg::WORK_W-1:0] work,
	input wire logic sgn,
	input wire logic signed [foru_pkg::EXP_W-1:0] exp_k,
	input wire foru_pkg::foru_fmt_t fmt,
	// packed result and range flags
	output logic [foru_pkg::OPND_W-1:0] packed_out,
	output logic ovf,
	output logic unf,
	output logic zero
);
	logic [foru_pkg::WORK_W-1:0] sum;
	logic [foru_pkg::WORK_W-1:0] rn;
	logic signed [foru_pkg::EXP_W-1:0] ex;
	logic signed [foru_pkg::EXP_W-1:0] biased;
	logic [foru_pkg::FRAC_W-1:0] f;

	always_comb begin
		zero = (work == '0);
		// one added at the first discarded bit; a set bit carries into the kept part
		sum = work + ({{(foru_pkg::WORK_W-1){1'b0}}, 1'b1}
			<< (foru_pkg::HID_POS - 1 - int'(foru_pkg::FRAC_BITS[fmt])));
		// carry out of the fraction: one right shift, new rounding bit is zero so no second pass
		if (sum[foru_pkg::WORK_W-1]) begin
			rn = sum >> 1;
			ex = exp_k + 18'sh00001;
		end else begin
			rn = sum;
			ex = exp_k;
		end
		biased = ex + foru_pkg::EXP_BIAS[fmt];
		// hidden bit dropped on writeback, truncation below the lsb
		f = rn[foru_pkg::HID_POS-1:2];
		ovf = !zero && (biased > foru_pkg::EXP_MAX[fmt]);
		unf = !zero && (biased < 18'sh00001);
		if (zero || unf) begin
			packed_out = '0;
		end else if (ovf) begin
			// the only source of a reserved pattern: sign set, exponent zero
			packed_out = {{(foru_pkg::OPND_W-1){1'b0}}, 1'b1} << (int'(foru_pkg::OPND_BITS[fmt]) - 1);
		end else begin
			case (fmt)
			foru_pkg::fmt_short: packed_out = {96'h0, sgn, biased[7:0], f[111:89]};
			foru_pkg::fmt_double_d: packed_out = {64'h0, sgn, biased[7:0], f[111:57]};
			foru_pkg::fmt_double_g: packed_out = {64'h0, sgn, biased[10:0], f[111:60]};
			default: packed_out = {sgn, biased[14:0], f};
			endcase
		end
	end
endmodule

// >>> rtl/foru_top.sv
// floating-point operand classify, arithmetic and rounding unit, top level
// Overview of operation
// - Operands are 32 bits in short format, 64 bits in both double formats and 128 bits in extended.
// - A clear sign with a zero exponent field means exact zero whatever the fraction holds.
// - Any zero result is written as the all-zero encoding.
// - A set sign with a zero exponent field is a reserved operand.
// - An operation faults instead of computing when any operand it reads is reserved.
// - A reserved pattern is produced internally only on exponent overflow.
// - Division by zero gives no quotient and signals a trap.
// - Zero operands of add, subtract, multiply, or a zero dividend, give exact results.
// - The working value carries one overflow bit on top and two guard bits at the bottom.
// - A set first discarded bit bumps the truncated result by one lsb, a clear one leaves it.
// - Rounding adds one at the rounding bit and lets the carry ripple upward.
// - A carry out of rounding is renormalized once and never twice.
// - Ops: add, clear, compare, both converts, divide, modulus, move, negate, multiply, polynomial_eval_op, subtract, test.
module foru_top (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// request from decode and operand fetch
	input wire logic req_valid,
	input wire foru_pkg::foru_op_t req_op,
	input wire foru_pkg::foru_fmt_t req_fmt,
	input wire foru_pkg::foru_fmt_t req_dst_fmt,
	input wire logic [foru_pkg::OPND_W-1:0] req_opnd_a,
	input wire logic [foru_pkg::OPND_W-1:0] req_opnd_b,
	input wire logic [foru_pkg::OPND_W-1:0] req_opnd_c,
	// completion, results and condition flags
	output logic busy,
	output logic done,
	output logic [foru_pkg::OPND_W-1:0] result,
	output logic [foru_pkg::INT_W-1:0] int_result,
	output logic cc_n,
	output logic cc_z,
	output logic cc_v,
	// exceptions
	output logic fault_reserved,
	output logic trap_div_zero
);
	localparam int WW = foru_pkg::WORK_W;
	localparam int MW = foru_pkg::MANT_W;

	typedef enum {st_idle, st_check, st_mul, st_div, st_norm} foru_state_t;

	foru_state_t state, next_state;
	foru_pkg::foru_op_t op, next_op;
	foru_pkg::foru_fmt_t fmt, next_fmt, dfmt, next_dfmt, rfmt;
	logic [foru_pkg::OPND_W-1:0] opnd [3];
	logic [foru_pkg::OPND_W-1:0] next_opnd [3];
	logic sgn, next_sgn, pass2, next_pass2;
	logic signed [foru_pkg::EXP_W-1:0] exp_k, next_exp_k;
	logic [WW-1:0] work, next_work;
	logic [MW:0] rem, next_rem;
	logic [MW-1:0] mplr, next_mplr;
	logic [foru_pkg::CNT_W-1:0] cnt, next_cnt;
	logic next_busy, next_done, next_cc_n, next_cc_z, next_cc_v, next_fault, next_trap;
	logic [foru_pkg::OPND_W-1:0] next_result;
	logic [foru_pkg::INT_W-1:0] next_int_result;

	// decoded operands
	logic cls_s [3];
	logic [foru_pkg::EXPF_W-1:0] cls_e [3];
	logic [MW-1:0] cls_m [3];
	logic cls_z [3];
	logic cls_r [3];
	logic signed [foru_pkg::EXP_W-1:0] cls_k [3];

	// one classifier per source operand
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_cls
			foru_classify u_cls (
				.raw(opnd[gi]),
				.fmt(fmt),
				.sgn(cls_s[gi]),
				.exp_field(cls_e[gi]),
				.mant(cls_m[gi]),
				.is_zero(cls_z[gi]),
				.is_rsvd(cls_r[gi])
			);
			assign cls_k[gi] = $signed({3'h0, cls_e[gi]}) - foru_pkg::EXP_BIAS[fmt];
		end
	endgenerate

	// rounding stage works on the current working value
	logic [foru_pkg::OPND_W-1:0] rpacked;
	logic r_ovf, r_unf, r_zero;
	assign rfmt = (op == foru_pkg::convert_op) ? dfmt : fmt;
	foru_round u_round (
		.work(work),
		.sgn(sgn),
		.exp_k(exp_k),
		.fmt(rfmt),
		.packed_out(rpacked),
		.ovf(r_ovf),
		.unf(r_unf),
		.zero(r_zero)
	);

	// operand reads per operation, reserved hit aborts before any arithmetic
	logic reads_a, reads_b, reads_c, rsvd_hit, is_add;
	assign is_add = (op == foru_pkg::add_op) || (op == foru_pkg::sub_op)
		|| (op == foru_pkg::polynomial_eval_op && pass2);
	assign reads_a = (op != foru_pkg::clear_op);
	assign reads_b = is_add || (op == foru_pkg::mul_op) || (op == foru_pkg::div_op) || (op == foru_pkg::cmp_op)
		|| (op == foru_pkg::extended_modulus_op) || (op == foru_pkg::polynomial_eval_op);
	assign reads_c = (op == foru_pkg::polynomial_eval_op) && !pass2;
	assign rsvd_hit = (reads_a && cls_r[0]) || (reads_b && cls_r[1]) || (reads_c && cls_r[2]);

	// alignment of the smaller addend; guards catch the first two bits shifted out
	logic a_big, sign_b;
	logic [foru_pkg::EXPF_W-1:0] e_diff;
	logic [WW-1:0] big_w, sml_w, add_w;
	assign a_big = (cls_e[0] > cls_e[1]) || ((cls_e[0] == cls_e[1]) && (cls_m[0] >= cls_m[1]));
	assign sign_b = cls_s[1] ^ (op == foru_pkg::sub_op);
	assign e_diff = a_big ? cls_e[0] - cls_e[1] : cls_e[1] - cls_e[0];
	assign big_w = {1'b0, (a_big ? cls_m[0] : cls_m[1]), 2'b00};
	assign sml_w = {1'b0, (a_big ? cls_m[1] : cls_m[0]), 2'b00} >> e_diff;
	assign add_w = (cls_s[0] == sign_b) ? big_w + sml_w : big_w - sml_w;

	// compare on sign, then exponent and mantissa as one magnitude
	logic cmp_eq, cmp_lt;
	assign cmp_eq = (cls_z[0] && cls_z[1])
		|| ((cls_s[0] == cls_s[1]) && (cls_e[0] == cls_e[1]) && (cls_m[0] == cls_m[1]));
	assign cmp_lt = !cmp_eq && ((cls_s[0] && !cls_s[1])
		|| ((cls_s[0] == cls_s[1]) && (cls_s[0] ^ ({cls_e[0], cls_m[0]} < {cls_e[1], cls_m[1]}))));

	// serial multiply and restoring divide steps
	logic [WW:0] mul_sum;
	logic [MW:0] div_diff, div_sel;
	logic div_ge;
	assign mul_sum = {1'b0, work} + (mplr[0] ? {2'b00, cls_m[0], 2'b00} : '0);
	assign div_ge = rem >= {1'b0, cls_m[1]};
	assign div_diff = rem - {1'b0, cls_m[1]};
	assign div_sel = div_ge ? div_diff : rem;

	// integer part and fraction part of the normalized working value
	logic [WW-1:0] int_bits, frac_keep, rnd_bits;
	logic [foru_pkg::INT_W-1:0] rnd_int;
	always_comb begin
		int_bits = '0;
		frac_keep = work;
		rnd_bits = '0;
		if (exp_k > 18'sh00000 && exp_k <= foru_pkg::INT_TOP) begin
			int_bits = work >> 8'(foru_pkg::INT_TOP - exp_k);
			frac_keep = work & ({WW{1'b1}} >> 8'(exp_k + 18'sh00001));
		end else if (exp_k > foru_pkg::INT_TOP) begin
			frac_keep = '0;
		end
		// convert rounded: keep one extra bit, add one, drop it
		if (exp_k >= 18'sh00000 && exp_k <= foru_pkg::RND_TOP) begin
			rnd_bits = ((work >> 8'(foru_pkg::RND_TOP - exp_k)) + 116'h1) >> 1;
		end
		rnd_int = sgn ? -rnd_bits[foru_pkg::INT_W-1:0] : rnd_bits[foru_pkg::INT_W-1:0];
	end

	// next-state and datapath control
	always_comb begin
		next_state = state;
		next_op = op;
		next_fmt = fmt;
		next_dfmt = dfmt;
		next_opnd = opnd;
		next_sgn = sgn;
		next_pass2 = pass2;
		next_exp_k = exp_k;
		next_work = work;
		next_rem = rem;
		next_mplr = mplr;
		next_cnt = cnt;
		next_result = result;
		next_int_result = int_result;
		next_cc_n = cc_n;
		next_cc_z = cc_z;
		next_cc_v = cc_v;
		next_done = 1'b0;
		next_fault = 1'b0;
		next_trap = 1'b0;
		case (state)
		st_idle: begin
			if (req_valid) begin
				next_op = req_op;
				next_fmt = req_fmt;
				next_dfmt = req_dst_fmt;
				next_opnd[0] = req_opnd_a;
				next_opnd[1] = req_opnd_b;
				next_opnd[2] = req_opnd_c;
				next_pass2 = 1'b0;
				next_state = st_check;
			end
		end
		st_check: begin
			next_cnt = '0;
			next_work = '0;
			next_state = st_norm;
			if (rsvd_hit) begin
				next_fault = 1'b1;
				next_done = 1'b1;
				next_state = st_idle;
			end else if (is_add) begin
				// a zero addend shifts in as zero, so the other operand passes exactly
				next_work = cls_z[1] ? {1'b0, cls_m[0], 2'b00} : add_w;
				next_sgn = a_big ? cls_s[0] : sign_b;
				next_exp_k = a_big ? cls_k[0] : cls_k[1];
			end else begin
				case (op)
				foru_pkg::clear_op: begin
					next_result = '0;
					next_cc_n = 1'b0;
					next_cc_z = 1'b1;
					next_cc_v = 1'b0;
					next_done = 1'b1;
					next_state = st_idle;
				end
				foru_pkg::cmp_op, foru_pkg::test_op: begin
					next_cc_n = (op == foru_pkg::cmp_op) ? cmp_lt : cls_s[0];
					next_cc_z = (op == foru_pkg::cmp_op) ? cmp_eq : cls_z[0];
					next_cc_v = 1'b0;
					next_done = 1'b1;
					next_state = st_idle;
				end
				foru_pkg::mul_op, foru_pkg::extended_modulus_op, foru_pkg::polynomial_eval_op: begin
					next_sgn = cls_s[0] ^ cls_s[1];
					next_exp_k = cls_k[0] + cls_k[1];
					next_mplr = cls_m[1];
					// a zero factor skips the loop and leaves an exact zero
					if (!(cls_z[0] || cls_z[1])) begin
						next_state = st_mul;
					end
				end
				foru_pkg::div_op: begin
					next_sgn = cls_s[0] ^ cls_s[1];
					next_exp_k = cls_k[0] - cls_k[1];
					next_rem = {1'b0, cls_m[0]};
					if (cls_z[1]) begin
						next_trap = 1'b1;
						next_done = 1'b1;
						next_state = st_idle;
					end else if (!cls_z[0]) begin
						next_state = st_div;
					end
				end
				default: begin
					// move, move negated and both converts repack operand a
					next_work = {1'b0, cls_m[0], 2'b00};
					next_sgn = cls_s[0] ^ ((op == foru_pkg::move_negated_op) && !cls_z[0]);
					next_exp_k = cls_k[0];
				end
				endcase
			end
		end
		st_mul: begin
			// truncation below the guards keeps the loop narrow
			next_work = mul_sum[WW:1];
			next_mplr = mplr >> 1;
			next_cnt = cnt + 7'h01;
			if (cnt == foru_pkg::MUL_LAST) begin
				next_state = st_norm;
			end
		end
		st_div: begin
			next_rem = {div_sel[MW-1:0], 1'b0};
			next_work = {work[WW-2:0], div_ge};
			next_cnt = cnt + 7'h01;
			if (cnt == foru_pkg::DIV_LAST) begin
				next_state = st_norm;
			end
		end
		st_norm: begin
			if (!r_zero && work[WW-1]) begin
				next_work = work >> 1;
				next_exp_k = exp_k + 18'sh00001;
			end else if (!r_zero && !work[foru_pkg::HID_POS]) begin
				next_work = work << 1;
				next_exp_k = exp_k - 18'sh00001;
			end else if (op == foru_pkg::extended_modulus_op && !pass2) begin
				// integer part out now, fraction renormalized on the second pass
				next_int_result = int_bits[foru_pkg::INT_W-1:0];
				next_work = frac_keep;
				next_pass2 = 1'b1;
			end else if (op == foru_pkg::polynomial_eval_op && !pass2) begin
				// rounded product becomes the augend of the coefficient add
				next_opnd[0] = rpacked;
				next_opnd[1] = opnd[2];
				next_pass2 = 1'b1;
				next_state = st_check;
			end else if (op == foru_pkg::convert_rounded_op) begin
				next_int_result = rnd_int;
				next_cc_n = rnd_int[foru_pkg::INT_W-1];
				next_cc_z = (rnd_int == 32'h0);
				next_cc_v = exp_k > foru_pkg::INT_MAX_K;
				next_done = 1'b1;
				next_state = st_idle;
			end else begin
				next_result = rpacked;
				next_cc_n = sgn && !r_zero && !r_unf;
				next_cc_z = r_zero || r_unf;
				next_cc_v = r_ovf;
				next_done = 1'b1;
				next_state = st_idle;
			end
		end
		default: next_state = st_idle;
		endcase
		next_busy = (next_state != st_idle);
	end

	// state and output registers
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state <= st_idle;
			op <= foru_pkg::clear_op;
			fmt <= foru_pkg::fmt_short;
			dfmt <= foru_pkg::fmt_short;
			opnd <= '{default: '0};
			sgn <= 1'b0;
			pass2 <= 1'b0;
			exp_k <= '0;
			work <= '0;
			rem <= '0;
			mplr <= '0;
			cnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			result <= '0;
			int_result <= '0;
			cc_n <= 1'b0;
			cc_z <= 1'b0;
			cc_v <= 1'b0;
			fault_reserved <= 1'b0;
			trap_div_zero <= 1'b0;
		end else begin
			state <= next_state;
			op <= next_op;
			fmt <= next_fmt;
			dfmt <= next_dfmt;
			opnd <= next_opnd;
			sgn <= next_sgn;
			pass2 <= next_pass2;
			exp_k <= next_exp_k;
			work <= next_work;
			rem <= next_rem;
			mplr <= next_mplr;
			cnt <= next_cnt;
			busy <= next_busy;
			done <= next_done;
			result <= next_result;
			int_result <= next_int_result;
			cc_n <= next_cc_n;
			cc_z <= next_cc_z;
			cc_v <= next_cc_v;
			fault_reserved <= next_fault;
			trap_div_zero <= next_trap;
		end
	end
endmodule

// >>> rtl/foru_round_note.sv
// holds no logic; rounding and packing sit in foru_round

// >>> dv/foru_chk_props.sv
// concurrent checks on the ports of the float operand and round unit
module foru_chk (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// request side
	input wire logic req_valid,
	input wire foru_pkg::foru_op_t req_op,
	input wire foru_pkg::foru_fmt_t req_fmt,
	input wire logic [foru_pkg::OPND_W-1:0] req_opnd_a,
	input wire logic [foru_pkg::OPND_W-1:0] req_opnd_b,
	// completion side
	input wire logic busy,
	input wire logic done,
	input wire logic [foru_pkg::OPND_W-1:0] result,
	input wire logic cc_n,
	input wire logic cc_z,
	input wire logic cc_v,
	input wire logic fault_reserved,
	input wire logic trap_div_zero
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	logic take;
	logic a_rsvd;
	logic b_zero;
	// short-format operand classes, only short is judged here
	assign take = req_valid && !busy;
	assign a_rsvd = req_fmt == foru_pkg::fmt_short && req_opnd_a[31:23] == 9'h100;
	assign b_zero = req_fmt == foru_pkg::fmt_short && req_opnd_b[31:23] == 9'h000;
	AST_TAKE_BUSY: assert property (take |=> busy) else $error("take did not raise busy");
	AST_DONE_PULSE: assert property (done |-> !busy ##1 !done) else $error("done not a single idle pulse");
	AST_FAULT_DONE: assert property (fault_reserved |-> done && !trap_div_zero) else $error("fault off done");
	AST_TRAP_DONE: assert property (trap_div_zero |-> done) else $error("trap off done");
	AST_HOLD_ON_EXC: assert property ((fault_reserved || trap_div_zero) |->
		$stable(result) && $stable({cc_n, cc_z, cc_v})) else $error("result moved on exception");
	AST_CLEAR_ZERO: assert property (take && req_op == foru_pkg::clear_op |->
		##2 done && result == '0 && cc_z) else $error("clear not all zero");
	AST_RSVD_FAULT: assert property (take && a_rsvd
		&& req_op inside {foru_pkg::add_op, foru_pkg::mul_op, foru_pkg::move_negated_op}
		|-> ##2 done && fault_reserved) else $error("reserved operand ran");
	AST_DIVZ_TRAP: assert property (take && req_op == foru_pkg::div_op && b_zero && !a_rsvd
		|-> ##2 done && trap_div_zero) else $error("no trap on zero divisor");
	AST_BUSY_BOUND: assert property ($rose(busy) |-> ##[1:400] !busy) else $error("busy too long");
	// main scenarios reached
	CVR_CLEAR: cover property (take && req_op == foru_pkg::clear_op);
	CVR_FAULT: cover property (fault_reserved);
	CVR_TRAP: cover property (trap_div_zero);
	CVR_OVF: cover property (done && cc_v && !fault_reserved);
endmodule

bind foru_top foru_chk u_chk (.clock(clock), .rstn(rstn), .req_valid(req_valid), .req_op(req_op),
	.req_fmt(req_fmt), .req_opnd_a(req_opnd_a), .req_opnd_b(req_opnd_b), .busy(busy), .done(done),
	.result(result), .cc_n(cc_n), .cc_z(cc_z), .cc_v(cc_v), .fault_reserved(fault_reserved),
	.trap_div_zero(trap_div_zero));

// >>> dv/foru_issuer.sv
// decode and operand fetch stand-in that presents one request at a time
module foru_issuer (
	// clock and handshake
	input wire logic clock,
	input wire logic busy,
	// request lines
	output foru_pkg::foru_op_t req_op,
	output foru_pkg::foru_fmt_t req_fmt,
	output foru_pkg::foru_fmt_t req_dst_fmt,
	output logic req_valid,
	output logic [foru_pkg::OPND_W-1:0] req_opnd_a,
	output logic [foru_pkg::OPND_W-1:0] req_opnd_b,
	output logic [foru_pkg::OPND_W-1:0] req_opnd_c
);
	timeunit 1ns;
	timeprecision 1ps;
	// quiet lines at time zero
	initial begin
		req_valid = 1'b0;
		req_op = foru_pkg::move_op;
		req_fmt = foru_pkg::fmt_short;
		req_dst_fmt = foru_pkg::fmt_short;
		req_opnd_a = '0;
		req_opnd_b = '0;
		req_opnd_c = '0;
	end
	// operands go out as plain values, never via an auto-modified register
	// hold everything until an edge sees busy low, then scramble the operands
	task automatic issue(input foru_pkg::foru_op_t op, input foru_pkg::foru_fmt_t f, input foru_pkg::foru_fmt_t d,
		input logic [127:0] a, input logic [127:0] b, input logic [127:0] c);
		@(posedge clock);
		req_valid <= 1'b1;
		req_op <= op;
		req_fmt <= f;
		req_dst_fmt <= d;
		req_opnd_a <= a;
		req_opnd_b <= b;
		req_opnd_c <= c;
		@(posedge clock);
		while (busy !== 1'b0) @(posedge clock);
		req_valid <= 1'b0;
		req_opnd_a <= ~a; // stale data must not look valid
		req_opnd_b <= ~b;
		req_opnd_c <= ~c;
	endtask
endmodule

// >>> dv/foru_top_tb.sv
// self-checking bench for the float operand and round unit, short and wide formats
module foru_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [1:0] kind;
		logic [127:0] res;
		logic [31:0] iv;
		logic [2:0] cc;
		logic [2:0] ccm;
		logic f;
		logic t;
	} foru_exp_t;
	localparam foru_pkg::foru_fmt_t S = foru_pkg::fmt_short;
	localparam logic [127:0] HALF = 128'h4000_0000;
	localparam logic [127:0] ONE = 128'h4080_0000;
	localparam logic [127:0] ONEH = 128'h40C0_0000;
	localparam logic [127:0] TWO = 128'h4100_0000;
	localparam logic [127:0] FOUR = 128'h4180_0000;
	logic clock;
	logic rstn;
	logic req_valid;
	foru_pkg::foru_op_t req_op;
	foru_pkg::foru_fmt_t req_fmt;
	foru_pkg::foru_fmt_t req_dst_fmt;
	logic [127:0] req_opnd_a;
	logic [127:0] req_opnd_b;
	logic [127:0] req_opnd_c;
	logic busy;
	logic done;
	logic [127:0] result;
	logic [31:0] int_result;
	logic cc_n;
	logic cc_z;
	logic cc_v;
	logic fault_reserved;
	logic trap_div_zero;
	foru_exp_t q[$];
	foru_exp_t e;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;
	logic [31:0] seed = 32'h0000_3F40;
	logic [31:0] junk;
	foru_top dut (.clock(clock), .rstn(rstn), .req_valid(req_valid), .req_op(req_op), .req_fmt(req_fmt),
		.req_dst_fmt(req_dst_fmt), .req_opnd_a(req_opnd_a), .req_opnd_b(req_opnd_b), .req_opnd_c(req_opnd_c),
		.busy(busy), .done(done), .result(result), .int_result(int_result), .cc_n(cc_n), .cc_z(cc_z),
		.cc_v(cc_v), .fault_reserved(fault_reserved), .trap_div_zero(trap_div_zero));
	foru_issuer u_iss (.clock(clock), .busy(busy), .req_op(req_op), .req_fmt(req_fmt), .req_dst_fmt(req_dst_fmt),
		.req_valid(req_valid), .req_opnd_a(req_opnd_a), .req_opnd_b(req_opnd_b), .req_opnd_c(req_opnd_c));
	// free-running 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		checks = checks + 1;
		if (seen !== exp) begin
			n_errors = n_errors + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// note the expectation first, then hand the request to the issuer
	task automatic run(input foru_pkg::foru_op_t op, input foru_pkg::foru_fmt_t d, input logic [127:0] a,
		input logic [127:0] b, input logic [127:0] c, input foru_exp_t x);
		q.push_back(x);
		u_iss.issue(op, S, d, a, b, c);
	endtask
	// completion watcher; values read at the edge are the settled ones of the done cycle
	always @(posedge clock) begin
		if (done === 1'b1) begin
			if (q.size() == 0) begin
				check(128'h1, 128'h0);
			end else begin
				e = q.pop_front();
				check({126'h0, fault_reserved, trap_div_zero}, {126'h0, e.f, e.t});
				if (e.kind == 2'h0) check(result, e.res);
				if (e.kind == 2'h2) check({96'h0, int_result}, {96'h0, e.iv});
				if (e.kind != 2'h3) check({125'h0, {cc_n, cc_z, cc_v} & e.ccm}, {125'h0, e.cc & e.ccm});
			end
		end
	end
	// hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors = n_errors + 1;
			end_of_test();
		end
	end
	initial begin
		rstn = 1'b0;
		repeat (8) @(posedge clock);
		rstn <= 1'b1;
		seed = xorshift(seed);
		junk = seed & 32'h007F_FFFF;
		// every operation, back to back since each request waits only for busy low
		run(foru_pkg::clear_op, S, ONE, ONE, 0, '{0, 0, 0, 3'h2, 3'h7, 0, 0});
		run(foru_pkg::add_op, S, ONE, ONE, 0, '{0, TWO, 0, 3'h0, 3'h7, 0, 0});
		run(foru_pkg::add_op, S, {96'h0, junk}, ONE, 0, '{0, ONE, 0, 3'h0, 3'h7, 0, 0});
		run(foru_pkg::sub_op, S, ONE, ONE, 0, '{0, 0, 0, 3'h2, 3'h7, 0, 0});
		run(foru_pkg::mul_op, S, TWO, TWO, 0, '{0, FOUR, 0, 3'h0, 3'h7, 0, 0});
		run(foru_pkg::mul_op, S, {96'h0, junk}, FOUR, 0, '{0, 0, 0, 3'h2, 3'h7, 0, 0});
		run(foru_pkg::div_op, S, ONE, TWO, 0, '{0, HALF, 0, 3'h0, 3'h7, 0, 0});
		run(foru_pkg::div_op, S, {96'h0, junk}, TWO, 0, '{0, 0, 0, 3'h2, 3'h7, 0, 0});
		run(foru_pkg::div_op, S, ONE, {96'h0, junk}, 0, '{3, 0, 0, 0, 0, 0, 1});
		run(foru_pkg::add_op, S, {96'h0, 32'h8000_0000 | junk}, ONE, 0, '{3, 0, 0, 0, 0, 1, 0});
		run(foru_pkg::move_negated_op, S, 32'h8000_0000, 0, 0, '{3, 0, 0, 0, 0, 1, 0});
		// half an lsb rounds up, a quarter does not, a carry out renormalizes once
		run(foru_pkg::add_op, S, ONE, 128'h3480_0000, 0, '{0, 128'h4080_0001, 0, 3'h0, 3'h7, 0, 0});
		run(foru_pkg::add_op, S, ONE, 128'h3400_0000, 0, '{0, ONE, 0, 3'h0, 3'h7, 0, 0});
		run(foru_pkg::add_op, S, 128'h407F_FFFF, 128'h3400_0000, 0, '{0, ONE, 0, 3'h0, 3'h7, 0, 0});
		run(foru_pkg::mul_op, S, 128'h7F80_0000, 128'h7F80_0000, 0, '{0, 128'h8000_0000, 0, 3'h1, 3'h1, 0, 0});
		run(foru_pkg::move_op, S, TWO, 0, 0, '{0, TWO, 0, 3'h0, 3'h7, 0, 0});
		run(foru_pkg::move_negated_op, S, ONE, 0, 0, '{0, 128'hC080_0000, 0, 3'h4, 3'h7, 0, 0});
		run(foru_pkg::move_negated_op, S, 0, 0, 0, '{0, 0, 0, 3'h2, 3'h7, 0, 0});
		run(foru_pkg::cmp_op, S, ONE, TWO, 0, '{1, 0, 0, 3'h4, 3'h6, 0, 0});
		run(foru_pkg::test_op, S, {96'h0, junk}, 0, 0, '{1, 0, 0, 3'h2, 3'h6, 0, 0});
		run(foru_pkg::convert_op, foru_pkg::fmt_extended, ONE, 0, 0,
			'{0, {16'h4001, 112'h0}, 0, 0, 3'h7, 0, 0});
		run(foru_pkg::convert_op, foru_pkg::fmt_double_g, ONE, 0, 0,
			'{0, 128'h4010_0000_0000_0000, 0, 0, 3'h7, 0, 0});
		run(foru_pkg::convert_rounded_op, S, ONEH, 0, 0, '{2, 0, 32'h0000_0002, 3'h0, 3'h6, 0, 0});
		run(foru_pkg::extended_modulus_op, S, ONEH, ONE, 0, '{2, 0, 32'h0000_0001, 0, 0, 0, 0});
		run(foru_pkg::polynomial_eval_op, S, ONE, TWO, TWO, '{0, FOUR, 0, 3'h0, 3'h7, 0, 0});
		repeat (400) begin
			if (q.size() != 0) @(posedge clock);
		end
		check({127'h0, q.size() == 0}, 128'h1);
		end_of_test();
	end
endmodule
